// File: design/issf_line_if.sv
`timescale 1ns/1ns
`default_nettype none
// conditioned i2c line events from the synchroniser to the flag logic
interface issf_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
   modport snk (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface
`default_nettype wire

// File: design/issf_line_sync.sv
`timescale 1ns/1ns
`default_nettype none
module issf_line_sync (
   input  wire logic i_mclk,     // peripheral clock
   input  wire logic i_rstn,     // async reset, active low
   input  wire logic i_scl,      // scl pin level
   input  wire logic i_sda,      // sda pin level
   issf_line_if.src  line        // conditioned levels and events
);
   logic [2:0] scl_ff, next_scl_ff;
   logic [2:0] sda_ff, next_sda_ff;
   logic       scl_lvl, next_scl_lvl;
   logic       sda_lvl, next_sda_lvl;
   logic       rise, next_rise;
   logic       fall, next_fall;
   logic       start, next_start;
   logic       stop, next_stop;

   ////////////////////////////////////////////////////////////////////////
   // a level counts only once stages two and three agree; stage one feeds stage two only
   always_comb begin
      next_scl_ff  = {scl_ff[1:0], i_scl};
      next_sda_ff  = {sda_ff[1:0], i_sda};
      next_scl_lvl = (scl_ff[1] == scl_ff[2]) ? scl_ff[2] : scl_lvl;
      next_sda_lvl = (sda_ff[1] == sda_ff[2]) ? sda_ff[2] : sda_lvl;
      next_rise    = next_scl_lvl & ~scl_lvl;
      next_fall    = ~next_scl_lvl & scl_lvl;
      // sda moving while scl stays high frames a transfer
      next_start   = ~next_sda_lvl & sda_lvl & scl_lvl & next_scl_lvl;
      next_stop    = next_sda_lvl & ~sda_lvl & scl_lvl & next_scl_lvl;
   end

   // idle bus is high, so reset to high to avoid a false start
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_ff  <= 3'h7;
         sda_ff  <= 3'h7;
         scl_lvl <= 1'b1;
         sda_lvl <= 1'b1;
         rise    <= 1'b0;
         fall    <= 1'b0;
         start   <= 1'b0;
         stop    <= 1'b0;
      end else begin
         scl_ff  <= next_scl_ff;
         sda_ff  <= next_sda_ff;
         scl_lvl <= next_scl_lvl;
         sda_lvl <= next_sda_lvl;
         rise    <= next_rise;
         fall    <= next_fall;
         start   <= next_start;
         stop    <= next_stop;
      end
   end

   assign line.scl       = scl_lvl;
   assign line.sda       = sda_lvl;
   assign line.scl_rise  = rise;
   assign line.scl_fall  = fall;
   assign line.start_det = start;
   assign line.stop_det  = stop;
endmodule
`default_nettype wire

// File: design/issf_pkg.sv
package issf_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [7:0]  ADR_CONTROL   = 8'h00;
   localparam logic [7:0]  ADR_STATUS    = 8'h04;
   localparam logic [7:0]  ADR_ID0       = 8'h08;
   localparam int          NUM_IDS       = 4;
   // slave_control_reg field positions
   localparam int          CTL_EARLY_EN  = 0;
   localparam int          CTL_NACK_EN   = 1;
   localparam int          CTL_RX_IRQ_EN = 2;
   localparam int          CTL_TX_IRQ_EN = 3;
   localparam int          CTL_GC_EN     = 4;
   localparam int          CTL_GC_CLR    = 5;
   localparam int          CTL_W         = 5;
   localparam logic [4:0]  CTL_RESET     = 5'h00;
   localparam logic [6:0]  ID_RESET      = 7'h00;
   // slave_status_reg field positions
   localparam int          ST_EARLY      = 0;
   localparam int          ST_UNDERFLOW  = 1;
   localparam int          ST_TX_REQ     = 2;
   localparam int          ST_RX_REQ     = 3;
   localparam int          ST_RX_OVF     = 4;
   localparam int          ST_NACK       = 5;
   localparam int          ST_BUSY       = 6;
   localparam int          ST_GC         = 7;
   localparam logic [6:0]  GC_ADDR       = 7'h00;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   localparam logic [3:0]  RW_BIT_IDX    = 4'h7;

   // bus protocol tracker states
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_ADDR   = 6'b000010,
      ST_AACK   = 6'b000100,
      ST_WDATA  = 6'b001000,
      ST_DACK   = 6'b010000,
      ST_IGNORE = 6'b100000
   } issf_state_t;
endpackage

// File: design/issf_top.sv
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module issf_top (
   input  wire logic                i_mclk,          // peripheral clock, 100 MHz
   input  wire logic                i_rstn,          // async reset, active low
   input  wire logic                i_wb_cyc,        // wishbone cycle
   input  wire logic                i_wb_stb,        // wishbone strobe
   input  wire logic                i_wb_we,         // wishbone write enable
   input  wire logic [7:0]          i_wb_adr,        // wishbone byte address
   input  wire logic [31:0]         i_wb_dat,        // wishbone write data
   input  wire logic [3:0]          i_wb_sel,        // wishbone byte lanes
   output logic      [31:0]         o_wb_dat,        // wishbone read data
   output logic                     o_wb_ack,        // wishbone acknowledge
   input  wire logic                i_scl,           // scl pin
   input  wire logic                i_sda,           // sda pin input
   output logic                     o_sda,           // sda pin output, always low
   output logic                     o_sda_oe,        // sda drive enable, high pulls low
   input  wire logic                i_rx_fifo_empty, // slave receive fifo empty
   input  wire logic                i_rx_fifo_full,  // slave receive fifo full
   input  wire logic                i_rx_fifo_wr,    // byte written to receive fifo
   input  wire logic                i_tx_fifo_empty, // slave transmit fifo empty
   output logic                     o_rx_irq,        // receive interrupt request
   output logic                     o_tx_irq         // transmit interrupt request
);
   import issf_pkg::*;

   issf_line_if line ();

   issf_line_sync u_sync (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .i_scl  (i_scl),
      .i_sda  (i_sda),
      .line   (line)
   );

   ////////////////////////////////////////////////////////////////////////
   // register file and wishbone slave
   logic [CTL_W-1:0] ctl, next_ctl;
   logic [6:0]       id [NUM_IDS], next_id [NUM_IDS];
   logic             ack, next_ack;
   logic [31:0]      rdat, next_rdat;
   logic [15:0]      status;
   logic             wr_fire, rd_status, gc_clr;

   // a write lands on the edge where the master samples ack
   assign wr_fire   = i_wb_cyc & i_wb_stb & i_wb_we & ack & i_wb_sel[0];
   assign rd_status = i_wb_cyc & i_wb_stb & ~i_wb_we & ack & (i_wb_adr == ADR_STATUS);
   assign gc_clr    = wr_fire & (i_wb_adr == ADR_CONTROL) & i_wb_dat[CTL_GC_CLR];

   always_comb begin
      next_ack  = i_wb_cyc & i_wb_stb & ~ack;
      next_ctl  = ctl;
      next_rdat = rdat;
      for (int k = 0; k < NUM_IDS; k++) begin
         next_id[k] = id[k];
      end
      if (wr_fire && i_wb_adr == ADR_CONTROL) begin
         next_ctl = i_wb_dat[CTL_W-1:0];
      end
      for (int k = 0; k < NUM_IDS; k++) begin
         if (wr_fire && i_wb_adr == ADR_ID0 + 8'(4 * k)) begin
            next_id[k] = i_wb_dat[6:0];
         end
      end
      // read data is latched on the same edge that raises ack; unmapped reads return zero
      if (next_ack) begin
         next_rdat = 32'h0000_0000;
         if (i_wb_adr == ADR_CONTROL) begin
            next_rdat = {27'h000_0000, ctl};
         end else if (i_wb_adr == ADR_STATUS) begin
            next_rdat = {16'h0000, status};
         end
         for (int k = 0; k < NUM_IDS; k++) begin
            if (i_wb_adr == ADR_ID0 + 8'(4 * k)) begin
               next_rdat = {25'h000_0000, id[k]};
            end
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ack  <= 1'b0;
         rdat <= 32'h0000_0000;
         ctl  <= CTL_RESET;
         for (int k = 0; k < NUM_IDS; k++) begin
            id[k] <= ID_RESET;
         end
      end else begin
         ack  <= next_ack;
         rdat <= next_rdat;
         ctl  <= next_ctl;
         for (int k = 0; k < NUM_IDS; k++) begin
            id[k] <= next_id[k];
         end
      end
   end

   assign o_wb_ack = ack;
   assign o_wb_dat = rdat;

   ////////////////////////////////////////////////////////////////////////
   // address comparison against each slave id
   logic [NUM_IDS-1:0] id_hit;
   logic               hit_now, gc_now, early_en, nack_en;
   logic [7:0]         shift, next_shift;

   for (genvar g = 0; g < NUM_IDS; g++) begin : g_match
      assign id_hit[g] = (shift[6:0] == id[g]);
   end
   assign hit_now  = |id_hit;
   assign gc_now   = ctl[CTL_GC_EN] & (shift[6:0] == GC_ADDR) & ~line.sda;
   assign early_en = ctl[CTL_EARLY_EN];
   assign nack_en  = ctl[CTL_NACK_EN];

   ////////////////////////////////////////////////////////////////////////
   // bus protocol tracker
   issf_state_t state, next_state;
   logic [3:0]  bitcnt, next_bitcnt;
   logic        hit_q, next_hit_q;
   logic        gc_q, next_gc_q;
   logic        rw_q, next_rw_q;
   logic        oe, next_oe;
   logic        rw_rise, decide, ack_ok;

   // rw_rise: rising scl of the direction bit; decide: falling scl ending the address byte
   assign rw_rise = (state == ST_ADDR) & line.scl_rise & (bitcnt == RW_BIT_IDX);
   assign decide  = (state == ST_ADDR) & line.scl_fall & (bitcnt == BITS_PER_BYTE);
   // reads are nacked when there is nothing to send
   assign ack_ok  = gc_q | (hit_q & ~nack_en & ~(rw_q & i_tx_fifo_empty));

   always_comb begin
      next_state  = state;
      next_shift  = shift;
      next_bitcnt = bitcnt;
      next_hit_q  = hit_q;
      next_gc_q   = gc_q;
      next_rw_q   = rw_q;
      next_oe     = oe;
      if (line.start_det) begin
         next_state  = ST_ADDR;
         next_bitcnt = 4'h0;
         next_oe     = 1'b0;
      end else if (line.stop_det) begin
         next_state = ST_IDLE;
         next_oe    = 1'b0;
      end else begin
         case (state)
            ST_ADDR: begin
               if (line.scl_rise) begin
                  next_shift  = {shift[6:0], line.sda};
                  next_bitcnt = bitcnt + 4'h1;
               end
               if (rw_rise) begin
                  next_hit_q = hit_now;
                  next_gc_q  = gc_now;
                  next_rw_q  = line.sda;
               end
               if (decide) begin
                  next_state = (hit_q | gc_q) ? ST_AACK : ST_IGNORE;
                  next_oe    = ack_ok;
               end
            end
            ST_AACK: begin
               if (line.scl_fall) begin
                  next_oe     = 1'b0;
                  next_bitcnt = 4'h0;
                  // no data path here: a read phase is only watched until the next stop or start
                  next_state  = (oe && !rw_q) ? ST_WDATA : ST_IGNORE;
               end
            end
            ST_WDATA: begin
               if (line.scl_rise) begin
                  next_bitcnt = bitcnt + 4'h1;
               end
               if (line.scl_fall && bitcnt == BITS_PER_BYTE) begin
                  next_state = ST_DACK;
                  next_oe    = ~nack_en;
               end
            end
            ST_DACK: begin
               if (line.scl_fall) begin
                  next_oe     = 1'b0;
                  next_bitcnt = 4'h0;
                  next_state  = oe ? ST_WDATA : ST_IGNORE;
               end
            end
            ST_IDLE, ST_IGNORE: begin
               next_oe = 1'b0;
            end
            default: begin
               next_state = ST_IDLE;
               next_oe    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         state  <= ST_IDLE;
         shift  <= 8'h00;
         bitcnt <= 4'h0;
         hit_q  <= 1'b0;
         gc_q   <= 1'b0;
         rw_q   <= 1'b0;
         oe     <= 1'b0;
      end else begin
         state  <= next_state;
         shift  <= next_shift;
         bitcnt <= next_bitcnt;
         hit_q  <= next_hit_q;
         gc_q   <= next_gc_q;
         rw_q   <= next_rw_q;
         oe     <= next_oe;
      end
   end

   assign o_sda    = 1'b0;
   assign o_sda_oe = oe;

   ////////////////////////////////////////////////////////////////////////
   // status flags; in every flag the set term is applied last so it wins
   logic busy, next_busy;
   logic nack, next_nack;
   logic ovf, next_ovf;
   logic rxq, next_rxq;
   logic txq, next_txq;
   logic ufl, next_ufl;
   logic etx, next_etx;
   logic etx_done, next_etx_done;
   logic gcf, next_gcf;
   logic etx_set;

   // early flag may fire once per transfer, then waits for a new start or stop
   assign etx_set = ~etx_done & (early_en ? (rw_rise & ~line.sda & hit_now)
                                          : (busy & i_tx_fifo_empty));

   always_comb begin
      next_busy     = busy;
      next_nack     = nack;
      next_ovf      = ovf;
      next_txq      = txq;
      next_ufl      = ufl;
      next_etx      = etx;
      next_etx_done = etx_done;
      next_gcf      = gcf;
      next_rxq      = ~i_rx_fifo_empty;
      if (line.stop_det || (decide && !hit_q && !gc_q)) begin
         next_busy = 1'b0;
      end
      if (line.start_det) begin
         next_busy = 1'b1;
      end
      // per-transfer flags fall back at every new start
      if (line.start_det) begin
         next_nack = 1'b0;
         next_ovf  = 1'b0;
         next_ufl  = 1'b0;
      end
      if (line.start_det || line.stop_det || !i_tx_fifo_empty) begin
         next_txq = 1'b0;
      end
      if (line.start_det || line.stop_det) begin
         next_etx_done = 1'b0;
      end
      if (rd_status) begin
         next_etx = 1'b0;
      end
      if (gc_clr) begin
         next_gcf = 1'b0;
      end
      if (decide && (hit_q | gc_q) && !ack_ok) begin
         next_nack = 1'b1;
      end
      if (i_rx_fifo_wr && i_rx_fifo_full) begin
         next_ovf = 1'b1;
      end
      if (early_en ? (rw_rise && line.sda && hit_now) : (decide && rw_q && hit_q)) begin
         next_txq = 1'b1;
      end
      if (rw_rise && line.sda && hit_now && i_tx_fifo_empty) begin
         next_ufl = 1'b1;
      end
      if (etx_set) begin
         next_etx      = 1'b1;
         next_etx_done = 1'b1;
      end
      if (decide && gc_q) begin
         next_gcf = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy     <= 1'b0;
         nack     <= 1'b0;
         ovf      <= 1'b0;
         rxq      <= 1'b0;
         txq      <= 1'b0;
         ufl      <= 1'b0;
         etx      <= 1'b0;
         etx_done <= 1'b0;
         gcf      <= 1'b0;
      end else begin
         busy     <= next_busy;
         nack     <= next_nack;
         ovf      <= next_ovf;
         rxq      <= next_rxq;
         txq      <= next_txq;
         ufl      <= next_ufl;
         etx      <= next_etx;
         etx_done <= next_etx_done;
         gcf      <= next_gcf;
      end
   end

   // status word; bits not built here read as zero
   always_comb begin
      status               = 16'h0000;
      status[ST_EARLY]     = etx;
      status[ST_UNDERFLOW] = ufl;
      status[ST_TX_REQ]    = txq;
      status[ST_RX_REQ]    = rxq;
      status[ST_RX_OVF]    = ovf;
      status[ST_NACK]      = nack;
      status[ST_BUSY]      = busy;
      status[ST_GC]        = gcf;
   end

   // request levels; they follow the flags, not sticky on their own
   assign o_rx_irq = rxq & ctl[CTL_RX_IRQ_EN];
   assign o_tx_irq = txq & ctl[CTL_TX_IRQ_EN];
endmodule
`default_nettype wire

// File: test/issf_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
module issf_i2c_master (
   input  wire logic i_sda_line, // resolved sda
   output var logic  o_scl,      // scl drive
   output var logic  o_sda       // sda drive, 1 releases
);
   ////////////////////////////////////////
   // scl stands still high between frames
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // data moves only while scl is low; the 1 ns lead keeps every pin move off the clock edge
   task bit_hi(input logic b);
      #1 o_sda = b;
      #30 o_scl = 1'b1;
      #32;
   endtask
   task bit_lo();
      #31 o_scl = 1'b0;
      #31;
   endtask
   task put(input logic [7:0] d, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         bit_hi(d[i]);
         bit_lo();
      end
   endtask
   // ninth clock: release sda, low means acknowledged
   task get_ack(output logic k);
      bit_hi(1'b1);
      k = !i_sda_line;
      bit_lo();
   endtask
   // also serves as repeated start from scl low
   task start();
      #1 o_sda = 1'b1;
      #30 o_scl = 1'b1;
      #31 o_sda = 1'b0;
      #31 o_scl = 1'b0;
      #32;
   endtask
   task stop();
      #1 o_sda = 1'b0;
      #30 o_scl = 1'b1;
      #31 o_sda = 1'b1;
      #31;
   endtask
endmodule
`default_nettype wire

// File: test/issf_properties.sv
`timescale 1ns/1ns
`default_nettype none
module issf_checker
   import issf_pkg::*;
(
   input  wire logic        i_mclk,          // clock
   input  wire logic        i_rstn,          // reset, active low
   input  wire logic        i_wb_cyc,        // bus cycle
   input  wire logic        i_wb_stb,        // bus strobe
   input  wire logic        i_wb_we,         // bus write
   input  wire logic [7:0]  i_wb_adr,        // bus address
   input  wire logic [31:0] o_wb_dat,        // read data
   input  wire logic        o_wb_ack,        // bus ack
   input  wire logic        i_scl,           // scl pin
   input  wire logic        o_sda_oe,        // sda pull enable
   input  wire logic        i_rx_fifo_empty, // rx fifo empty
   input  wire logic        o_rx_irq,        // rx irq
   input  wire logic        o_tx_irq         // tx irq
);
   logic [3:0] scl_age;
   logic [3:0] next_scl_age;
   logic       scl_q;
   logic       next_scl_q;
   ////////////////////////////////////////
   // cycles since scl moved, saturating so a long idle never wraps
   always_comb begin
      next_scl_q   = i_scl;
      next_scl_age = (i_scl != scl_q) ? 4'h0 : scl_age + {3'h0, scl_age != 4'hf};
   end
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_age <= 4'hf;
         scl_q   <= 1'b1;
      end else begin
         scl_age <= next_scl_age;
         scl_q   <= next_scl_q;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // bus handshake
   ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held too long");
   ack_follows_req_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack missing after request");
   ack_needs_req_a: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
      else $error("ack without request");
   unmapped_zero_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr > 8'h14 |-> o_wb_dat == 32'h0)
      else $error("unmapped read not zero");
   status_width_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == ADR_STATUS |-> o_wb_dat[31:8] == 24'h0)
      else $error("status upper bits set");
   // flag and sda drive outputs against their causes
   rx_irq_idle_a: assert property ($past(i_rx_fifo_empty) |-> !o_rx_irq)
      else $error("rx irq with empty fifo");
   tx_irq_edge_a: assert property ($rose(o_tx_irq) && !$past(o_wb_ack) |-> scl_age <= 4'h8)
      else $error("tx irq rose away from an scl edge");
   ack_drive_a: assert property ($rose(o_sda_oe) |-> !$past(i_scl, 3))
      else $error("sda pulled outside scl low");
   ack_release_a: assert property ($fell(o_sda_oe) |-> !$past(i_scl, 3))
      else $error("sda released outside scl low");
   cover property ($rose(o_sda_oe));
   cover property ($rose(o_tx_irq));
   cover property ($rose(o_rx_irq));
endmodule
`default_nettype wire

// File: test/issf_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module issf_top_tb;
   import issf_pkg::*;
   logic        clk, rstn, cyc, stb, we, rx_empty, rx_full, rx_wr, tx_empty;
   logic        ack, sda_oe, sda_o, rx_irq, tx_irq, m_scl, m_sda, a;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, q;
   int          bad_count, num_checks;
   // open drain with pull-up: low if either side pulls
   wire         sda_line = m_sda & (sda_oe ? sda_o : 1'b1);
   ////////////////////////////////////////
   issf_top i_dut (.i_mclk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'h1), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_scl(m_scl), .i_sda(sda_line), .o_sda(sda_o), .o_sda_oe(sda_oe),
      .i_rx_fifo_empty(rx_empty), .i_rx_fifo_full(rx_full), .i_rx_fifo_wr(rx_wr),
      .i_tx_fifo_empty(tx_empty), .o_rx_irq(rx_irq), .o_tx_irq(tx_irq));
   issf_i2c_master m (.i_sda_line(sda_line), .o_scl(m_scl), .o_sda(m_sda));
   // free running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // classic cycle held until ack is sampled; no fixed latency assumed
   task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) bad_count++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task st(input logic [31:0] e);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(q, e);
   endtask
   task w4();
      repeat (4) @(posedge clk);
   endtask
   ////////////////////////////////////////
   task t_reset();
      st(32'h0);
      wb(1'b1, 8'h40, 32'hff);
      wb(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, ADR_ID0, 32'h0);
      chk(q, 32'h0);
   endtask
   task t_write_hit();
      wb(1'b1, ADR_CONTROL, 32'h1);
      wb(1'b1, ADR_ID0, 32'h3a);
      m.start();
      w4();
      st(32'h40);
      m.put(8'h74, 7);
      m.bit_hi(1'b0);
      w4();
      st(32'h41);
      st(32'h40);
      m.bit_lo();
      m.get_ack(a);
      chk({31'h0, a}, 32'h1);
      m.put(8'h55, 8);
      m.get_ack(a);
      st(32'h40);
      m.stop();
      w4();
      st(32'h0);
   endtask
   // early enable moves the transmit request from the fall to the rise
   task t_read(input logic e);
      wb(1'b1, ADR_CONTROL, {28'h0, 3'h4, e});
      m.start();
      w4();
      st(e ? 32'h40 : 32'h41);
      st(32'h40);
      m.put(8'h75, 7);
      m.bit_hi(1'b1);
      w4();
      st(e ? 32'h46 : 32'h42);
      chk({31'h0, tx_irq}, {31'h0, e});
      m.bit_lo();
      w4();
      st(32'h66);
      chk({31'h0, tx_irq}, 32'h1);
      m.get_ack(a);
      chk({31'h0, a}, 32'h0);
      w4();
      st(32'h66);
      m.stop();
      w4();
      st(32'h22);
   endtask
   task t_mismatch();
      tx_empty <= 1'b0;
      wb(1'b1, ADR_CONTROL, 32'h2);
      m.start();
      m.put(8'h74, 8);
      m.get_ack(a);
      chk({31'h0, a}, 32'h0);
      w4();
      st(32'h60);
      m.start();
      w4();
      st(32'h40);
      m.put(8'h22, 8);
      m.get_ack(a);
      w4();
      st(32'h0);
      m.stop();
   endtask
   task t_gc();
      wb(1'b1, ADR_CONTROL, 32'h10);
      m.start();
      m.put(8'h00, 8);
      m.get_ack(a);
      w4();
      st(32'hc0);
      m.stop();
      w4();
      st(32'h80);
      st(32'h80);
      wb(1'b1, ADR_CONTROL, 32'h30);
      st(32'h0);
   endtask
   task t_rx();
      rx_empty <= 1'b0;
      st(32'h08);
      chk({31'h0, rx_irq}, 32'h0);
      wb(1'b1, ADR_CONTROL, 32'h4);
      @(posedge clk);
      chk({31'h0, rx_irq}, 32'h1);
      rx_wr <= 1'b1;
      @(posedge clk);
      rx_wr <= 1'b0;
      st(32'h08);
      rx_full <= 1'b1;
      rx_wr <= 1'b1;
      @(posedge clk);
      rx_wr <= 1'b0;
      st(32'h18);
      rx_empty <= 1'b1;
      rx_full <= 1'b0;
      st(32'h10);
      chk({31'h0, rx_irq}, 32'h0);
   endtask
   ////////////////////////////////////////
   task close_out();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      {rstn, cyc, stb, we, rx_full, rx_wr} = 6'h0;
      {adr, wdat} = 40'h0;
      rx_empty = 1'b1;
      tx_empty = 1'b1;
      bad_count = 0;
      num_checks = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_write_hit();
      t_read(1'b0);
      t_read(1'b1);
      t_mismatch();
      t_gc();
      t_rx();
      close_out();
   end
   // hang guard, far beyond the roughly 11 microseconds the run needs
   initial begin
      #400000;
      bad_count++;
      close_out();
   end
endmodule
bind issf_top issf_checker u_chk (
   .i_mclk          (i_mclk),
   .i_rstn          (i_rstn),
   .i_wb_cyc        (i_wb_cyc),
   .i_wb_stb        (i_wb_stb),
   .i_wb_we         (i_wb_we),
   .i_wb_adr        (i_wb_adr),
   .o_wb_dat        (o_wb_dat),
   .o_wb_ack        (o_wb_ack),
   .i_scl           (i_scl),
   .o_sda_oe        (o_sda_oe),
   .i_rx_fifo_empty (i_rx_fifo_empty),
   .o_rx_irq        (o_rx_irq),
   .o_tx_irq        (o_tx_irq)
);
`default_nettype wire
